// ==== periph_model.sv ====
// far side: peripheral outputs and resolved pad wires
`timescale 1ns/10ps
module periph_model (
   input wire logic clk_in,
   input wire logic [7:0] pad_out_in,
   input wire logic [7:0] pad_oe_in,
   input wire logic [7:0] pullup_in,
   input wire logic [7:0] ext_level_in,
   input wire logic [7:0] ext_drive_in,
   input wire port_crossbar_pkg::periph_out_s periph_val_in,
   output logic [7:0] pad_level_out,
   output port_crossbar_pkg::periph_out_s periph_out
);
   logic toggle_q = 1'b0;
   always @(posedge clk_in) begin
      toggle_q <= ~toggle_q;
   end
   // an undriven pin without pull-up floats: it changes every cycle
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe_in[i]) pad_level_out[i] = pad_out_in[i];
         else if (ext_drive_in[i]) pad_level_out[i] = ext_level_in[i];
         else if (pullup_in[i]) pad_level_out[i] = 1'b1;
         else pad_level_out[i] = toggle_q;
      end
   end
   always_comb begin
      periph_out = periph_val_in;
      periph_out.system_clock_out = toggle_q;
   end
endmodule

// ==== pin_assign_map.sv ====
// priority search that gives each enabled function its pin, held in a register
`timescale 1ns/10ps
module pin_assign_map #(
   parameter int FUNCS = port_crossbar_pkg::FUNC_COUNT
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [FUNCS-1:0] func_req_in,
   input wire logic [7:0] blocked_in,
   output logic [FUNCS-1:0][7:0] func_pin_out,
   output logic [7:0] pin_used_out
);

   // ---------------------------------------------------------------
   // search chain
   // ---------------------------------------------------------------
   logic [FUNCS:0][7:0] taken;
   logic [FUNCS-1:0][7:0] grant;

   assign taken[0] = blocked_in;

   genvar f;
   generate
      for (f = 0; f < FUNCS; f++) begin : g_slot
         wire [7:0] free_pins = ~taken[f];
         wire [7:0] lowest = free_pins & (~free_pins + 8'h01);
         assign grant[f] = func_req_in[f] ? lowest : 8'h00;
         assign taken[f+1] = taken[f] | grant[f];
      end
   endgenerate

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         func_pin_out <= '0;
         pin_used_out <= 8'h00;
      end else begin
         func_pin_out <= grant;
         pin_used_out <= taken[FUNCS] & ~blocked_in;
      end
   end

endmodule

// ==== port_crossbar_pkg.sv ====
// shared constants and carrier types for the priority port crossbar
package port_crossbar_pkg;

   // ---------------------------------------------------------------
   // sizes and fixed pin positions
   // ---------------------------------------------------------------
   localparam int PIN_COUNT = 8;
   localparam int SKIP_WIDTH = 7;
   localparam int FUNC_COUNT = 12;
   localparam int PIN_IDX_W = 3;
   localparam logic [2:0] SERIAL_TX_PIN = 3'h4;
   localparam logic [2:0] SERIAL_RX_PIN = 3'h5;

   // ---------------------------------------------------------------
   // function slots in priority order (serial port handled apart)
   // ---------------------------------------------------------------
   localparam int F_TWI_DATA = 0;
   localparam int F_TWI_CLOCK = 1;
   localparam int F_CMP_SYNC = 2;
   localparam int F_CMP_ASYNC = 3;
   localparam int F_SYSTEM_CLOCK_OUT = 4;
   localparam int F_CCH0 = 5;
   localparam int F_CCH1 = 6;
   localparam int F_CCH2 = 7;
   localparam int F_CNT_IN = 8;
   localparam int F_TMR_ZERO = 9;
   localparam int F_TMR_ONE = 10;
   localparam int F_SPARE = 11;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] INPUT_MODE_RST = 8'hFF;
   localparam logic [7:0] OUTPUT_MODE_RST = 8'h00;
   localparam logic [7:0] LATCH_RST = 8'hFF;
   localparam logic [6:0] SKIP_RST = 7'h00;
   localparam logic [7:0] ROUTE_A_RST = 8'h00;
   localparam logic [7:0] ROUTE_B_RST = 8'h00;

   // ---------------------------------------------------------------
   // event capture edge selection
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EDGE_NONE,
      EDGE_RISE,
      EDGE_FALL,
      EDGE_BOTH
   } edge_mode_e;

   // ---------------------------------------------------------------
   // carrier structs
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] counter_array_route_field;
      logic cmp_async_en;
      logic cmp_sync_en;
      logic system_clock_out_en;
      logic twi_en;
      logic serial_rx_en;
      logic serial_tx_en;
   } route_a_s;

   typedef struct packed {
      logic pullup_disable_bit;
      logic crossbar_enable_bit;
      logic [2:0] unused;
      logic timer_one_en;
      logic timer_zero_en;
      logic counter_input_en;
   } route_b_s;

   typedef struct packed {
      logic [2:0] pin_sel;
      edge_mode_e edge_mode;
   } event_cfg_s;

   typedef struct packed {
      logic serial_transmit;
      logic twi_data;
      logic twi_clock;
      logic comparator_sync_out;
      logic comparator_async_out;
      logic system_clock_out;
      logic [2:0] capture_compare_channels;
   } periph_out_s;

endpackage

// ==== priority_port_crossbar.sv ====
// eight-pin port with priority crossbar, pin modes, pull-ups and event capture
// How it works
// - skipped pins never given to peripherals other than the fixed serial pins
// - each function gets lowest free pin
// - serial transmit pin 4, receive pin 5
// - assigned pin passed over by next function
// - skipped pins treated as already assigned
// - two-wire data and clock placed together
// - leftover unskipped pins are plain port pins
// - pin transition raises event pulse
// - capture works on any digital pin
// - analog pins never detect transitions
// - input mode bit one means digital
// - reset makes every pin digital
// - analog pin: no pull-up, driver, receiver
// - drive type from output mode bit, except two-wire pins
// - two-wire pins always open-drain
// - pull-ups on open-drain pins unless disabled
// - pull-up off while pin drives zero
// - crossbar off: pins plain port inputs
// - crossbar off: all drivers disabled
// - enable bit one activates routing
// - skip field bits 6 to 0
// - counter-array field routes zero to three channels
// - port reads pins, modify reads latch
// - analog pins read as zero
`timescale 1ns/10ps
module priority_port_crossbar #(
   parameter int PINS = port_crossbar_pkg::PIN_COUNT
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [6:0] pin_skip_reg_in,
   input wire port_crossbar_pkg::route_a_s peripheral_route_reg_a_in,
   input wire port_crossbar_pkg::route_b_s peripheral_route_reg_b_in,
   input wire logic [7:0] port_input_mode_in,
   input wire logic [7:0] port_output_mode_in,
   input wire logic cfg_write_in,
   input wire logic [7:0] latch_wdata_in,
   input wire logic latch_write_in,
   input wire logic latch_rmw_in,
   input wire port_crossbar_pkg::event_cfg_s ext_interrupt_config_in,
   input wire port_crossbar_pkg::periph_out_s periph_out_in,
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe_out,
   output logic [7:0] pad_pullup_out,
   output logic [7:0] port_read_out,
   output logic serial_receive_out,
   output logic twi_data_in_out,
   output logic twi_clock_in_out,
   output logic counter_external_input_out,
   output logic timer_zero_input_out,
   output logic timer_one_input_out,
   output logic event_pulse_out,
   output logic [7:0] pin_routed_out,
   output logic crossbar_active_out
);

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   logic [6:0] skip_q;
   port_crossbar_pkg::route_a_s route_a_q;
   port_crossbar_pkg::route_b_s route_b_q;
   logic [7:0] in_mode_q;
   logic [7:0] out_mode_q;
   logic [7:0] latch_q;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         skip_q <= port_crossbar_pkg::SKIP_RST;
         route_a_q <= port_crossbar_pkg::ROUTE_A_RST;
         route_b_q <= port_crossbar_pkg::ROUTE_B_RST;
         in_mode_q <= port_crossbar_pkg::INPUT_MODE_RST;
         out_mode_q <= port_crossbar_pkg::OUTPUT_MODE_RST;
      end else if (cfg_write_in) begin
         skip_q <= pin_skip_reg_in;
         route_a_q <= peripheral_route_reg_a_in;
         route_b_q <= peripheral_route_reg_b_in;
         in_mode_q <= port_input_mode_in;
         out_mode_q <= port_output_mode_in;
      end
   end

   // ---------------------------------------------------------------
   // port latch with read-modify-write from the latch
   // ---------------------------------------------------------------
   // modify uses latch, not pins
   wire [7:0] latch_d = latch_rmw_in ? (latch_q & latch_wdata_in) : latch_wdata_in;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         latch_q <= port_crossbar_pkg::LATCH_RST;
      end else if (latch_write_in | latch_rmw_in) begin
         latch_q <= latch_d;
      end
   end

   // ---------------------------------------------------------------
   // pad input synchroniser
   // ---------------------------------------------------------------
   logic [7:0] pad_meta_q;
   logic [7:0] pad_sync_q;
   logic [7:0] pad_prev_q;

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         // pads idle high under the reset pull-ups, so no false edge follows reset
         pad_meta_q <= 8'hFF;
         pad_sync_q <= 8'hFF;
         pad_prev_q <= 8'hFF;
      end else begin
         pad_meta_q <= pad_in;
         pad_sync_q <= pad_meta_q;
         pad_prev_q <= pad_sync_q;
      end
   end

   // ---------------------------------------------------------------
   // requests and blocked pins
   // ---------------------------------------------------------------
   // routing only when enabled
   wire xbar_en = route_b_q.crossbar_enable_bit;
   wire [1:0] cc_sel = route_a_q.counter_array_route_field;
   wire tx_en = xbar_en & route_a_q.serial_tx_en;
   wire rx_en = xbar_en & route_a_q.serial_rx_en;

   // slot order is the priority order
   wire [port_crossbar_pkg::FUNC_COUNT-1:0] req = {
      1'b0,
      route_b_q.timer_one_en,
      route_b_q.timer_zero_en,
      route_b_q.counter_input_en,
      (cc_sel == 2'h3),
      (cc_sel >= 2'h2),
      (cc_sel != 2'h0),
      route_a_q.system_clock_out_en,
      route_a_q.cmp_async_en,
      route_a_q.cmp_sync_en,
      route_a_q.twi_en,
      route_a_q.twi_en
   } & {port_crossbar_pkg::FUNC_COUNT{xbar_en}};

   // serial pins fixed and taken first
   wire [7:0] serial_pins = ({7'h00, tx_en} << port_crossbar_pkg::SERIAL_TX_PIN)
                          | ({7'h00, rx_en} << port_crossbar_pkg::SERIAL_RX_PIN);
   wire [7:0] blocked = {1'b0, skip_q} | serial_pins;

   logic [port_crossbar_pkg::FUNC_COUNT-1:0][7:0] func_pin;
   logic [7:0] pin_used;

   pin_assign_map #(
      .FUNCS(port_crossbar_pkg::FUNC_COUNT)
   ) u_map (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .func_req_in(req),
      .blocked_in(blocked),
      .func_pin_out(func_pin),
      .pin_used_out(pin_used)
   );

   logic [7:0] serial_pins_q;
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         serial_pins_q <= 8'h00;
      end else begin
         serial_pins_q <= serial_pins;
      end
   end

   // ---------------------------------------------------------------
   // per-pin output selection
   // ---------------------------------------------------------------
   wire [port_crossbar_pkg::FUNC_COUNT-1:0] fval = {
      1'b1, 1'b1, 1'b1, 1'b1,
      periph_out_in.capture_compare_channels[2],
      periph_out_in.capture_compare_channels[1],
      periph_out_in.capture_compare_channels[0],
      periph_out_in.system_clock_out,
      periph_out_in.comparator_async_out,
      periph_out_in.comparator_sync_out,
      periph_out_in.twi_clock,
      periph_out_in.twi_data
   };
   wire [7:0] digital = in_mode_q;
   wire [7:0] rx_view = pad_sync_q & digital;
   logic [7:0] val_d;
   logic [7:0] oe_d;
   logic [7:0] pu_d;
   logic [7:0] routed;
   logic [7:0] tx_pins_now;

   assign tx_pins_now = xbar_en & route_a_q.serial_tx_en ? serial_pins_q & 8'h10 : 8'h00;

   genvar p;
   generate
      for (p = 0; p < PINS; p++) begin : g_pin
         logic [port_crossbar_pkg::FUNC_COUNT-1:0] hit;
         logic sel_val;
         logic is_twi;
         logic open_drain;
         for (genvar k = 0; k < port_crossbar_pkg::FUNC_COUNT; k++) begin : g_hit
            assign hit[k] = func_pin[k][p];
         end
         assign sel_val = tx_pins_now[p] ? periph_out_in.serial_transmit :
                          (|(hit & fval)) | ((~|hit) & latch_q[p]);
         assign is_twi = hit[port_crossbar_pkg::F_TWI_DATA] | hit[port_crossbar_pkg::F_TWI_CLOCK];
         // drive type from mode bit, forced open-drain on two-wire pins
         assign open_drain = ~out_mode_q[p] | is_twi;
         assign routed[p] = pin_used[p] | serial_pins_q[p];
         assign val_d[p] = sel_val;
         assign oe_d[p] = xbar_en & digital[p] & ~(serial_pins_q[p] & ~tx_pins_now[p])
                          & (~open_drain | ~sel_val);
         assign pu_d[p] = digital[p] & (~xbar_en | open_drain) & ~route_b_q.pullup_disable_bit
                          & ~(oe_d[p] & ~sel_val);
      end
   endgenerate

   // ---------------------------------------------------------------
   // inputs routed back to peripherals
   // ---------------------------------------------------------------
   wire [7:0] twi_d_pins = func_pin[port_crossbar_pkg::F_TWI_DATA];
   wire [7:0] twi_c_pins = func_pin[port_crossbar_pkg::F_TWI_CLOCK];
   wire [7:0] cnt_in_pins = func_pin[port_crossbar_pkg::F_CNT_IN];
   wire [7:0] tmz_pins = func_pin[port_crossbar_pkg::F_TMR_ZERO];
   wire [7:0] tmo_pins = func_pin[port_crossbar_pkg::F_TMR_ONE];
   wire rx_pin_on = rx_en & serial_pins_q[port_crossbar_pkg::SERIAL_RX_PIN];

   // ---------------------------------------------------------------
   // external event capture
   // ---------------------------------------------------------------
   wire [2:0] ev_pin = ext_interrupt_config_in.pin_sel;
   // any digital pin, routed or not
   wire ev_cur = rx_view[ev_pin];
   wire ev_old = pad_prev_q[ev_pin] & digital[ev_pin];
   wire ev_rise = ev_cur & ~ev_old;
   wire ev_fall = ~ev_cur & ev_old;
   logic ev_hit;
   always_comb begin
      unique case (ext_interrupt_config_in.edge_mode)
         port_crossbar_pkg::EDGE_NONE: ev_hit = 1'b0;
         port_crossbar_pkg::EDGE_RISE: ev_hit = ev_rise;
         port_crossbar_pkg::EDGE_FALL: ev_hit = ev_fall;
         port_crossbar_pkg::EDGE_BOTH: ev_hit = ev_rise | ev_fall;
      endcase
   end

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         pad_out <= 8'hFF;
         pad_oe_out <= 8'h00;
         pad_pullup_out <= 8'hFF;
         port_read_out <= 8'h00;
         serial_receive_out <= 1'b1;
         twi_data_in_out <= 1'b1;
         twi_clock_in_out <= 1'b1;
         counter_external_input_out <= 1'b0;
         timer_zero_input_out <= 1'b0;
         timer_one_input_out <= 1'b0;
         event_pulse_out <= 1'b0;
         pin_routed_out <= 8'h00;
         crossbar_active_out <= 1'b0;
      end else begin
         pad_out <= val_d;
         pad_oe_out <= oe_d;
         pad_pullup_out <= pu_d;
         port_read_out <= rx_view;
         serial_receive_out <= rx_pin_on ? rx_view[port_crossbar_pkg::SERIAL_RX_PIN] : 1'b1;
         twi_data_in_out <= (|twi_d_pins) ? |(twi_d_pins & rx_view) : 1'b1;
         twi_clock_in_out <= (|twi_c_pins) ? |(twi_c_pins & rx_view) : 1'b1;
         counter_external_input_out <= |(cnt_in_pins & rx_view);
         timer_zero_input_out <= |(tmz_pins & rx_view);
         timer_one_input_out <= |(tmo_pins & rx_view);
         event_pulse_out <= ev_hit;
         pin_routed_out <= routed;
         crossbar_active_out <= xbar_en;
      end
   end

endmodule

// ==== priority_port_crossbar_properties.sv ====
// port-level assertions for the priority port crossbar
`timescale 1ns/10ps
module priority_port_crossbar_properties (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [6:0] pin_skip_reg_in,
   input wire port_crossbar_pkg::route_a_s peripheral_route_reg_a_in,
   input wire port_crossbar_pkg::route_b_s peripheral_route_reg_b_in,
   input wire logic [7:0] port_input_mode_in,
   input wire logic cfg_write_in,
   input wire port_crossbar_pkg::event_cfg_s ext_interrupt_config_in,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_out,
   input wire logic [7:0] pad_pullup_out,
   input wire logic [7:0] port_read_out,
   input wire logic event_pulse_out,
   input wire logic [7:0] pin_routed_out
);
   wire xbar_on = peripheral_route_reg_b_in.crossbar_enable_bit;
   wire [1:0] ser_on = {peripheral_route_reg_a_in.serial_rx_en, peripheral_route_reg_a_in.serial_tx_en} & {2{xbar_on}};
   wire twi_cfg = xbar_on & peripheral_route_reg_a_in.twi_en & ~|pin_skip_reg_in[1:0];
   wire [2:0] ev_pin = ext_interrupt_config_in.pin_sel;
   wire ev_rise = ext_interrupt_config_in.edge_mode == port_crossbar_pkg::EDGE_RISE;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ---------------------------------------------------------------
   // a config write followed by quiet cycles
   // ---------------------------------------------------------------
   sequence s_cfg_settled;
      cfg_write_in ##1 !cfg_write_in [*2];
   endsequence
   sequence s_cfg_long;
      cfg_write_in ##1 !cfg_write_in [*5];
   endsequence
   property p_skip_kept;
      s_cfg_settled |=> (pin_routed_out[6:0] & $past(pin_skip_reg_in, 3) & ~{1'b0, $past(ser_on, 3), 4'h0}) == 7'h00;
   endproperty
   a_skip_kept: assert property (p_skip_kept) else $error("skipped pin routed");
   property p_serial_fixed;
      s_cfg_settled |=> (pin_routed_out[5:4] | ~$past(ser_on, 3)) == 2'h3;
   endproperty
   a_serial_fixed: assert property (p_serial_fixed) else $error("serial pins misplaced");
   property p_twi_pair;
      s_cfg_settled |=> !$past(twi_cfg, 3) || (pin_routed_out[1:0] == 2'h3 && (pad_oe_out[1:0] & pad_out[1:0]) == 2'h0);
   endproperty
   a_twi_pair: assert property (p_twi_pair) else $error("two-wire pins wrong");
   property p_xbar_off;
      s_cfg_settled |=> $past(xbar_on, 3) || (pad_oe_out | pin_routed_out) == 8'h00;
   endproperty
   a_xbar_off: assert property (p_xbar_off) else $error("driver while crossbar off");
   property p_analog_quiet;
      s_cfg_settled |=> ((pad_oe_out | pad_pullup_out) & ~$past(port_input_mode_in, 3)) == 8'h00;
   endproperty
   a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin active");
   property p_analog_read;
      s_cfg_long |=> (port_read_out & ~$past(port_input_mode_in, 6)) == 8'h00;
   endproperty
   a_analog_read: assert property (p_analog_read) else $error("analog pin reads one");
   property p_low_no_pull;
      (pad_oe_out & ~pad_out & pad_pullup_out) == 8'h00;
   endproperty
   a_low_no_pull: assert property (p_low_no_pull) else $error("pull-up on low pin");
   property p_event_rise;
      $past(ev_rise) && port_read_out[$past(ev_pin)] && !$past(port_read_out[ev_pin]) |-> event_pulse_out;
   endproperty
   a_event_rise: assert property (p_event_rise) else $error("edge missed");
   property p_event_cause;
      event_pulse_out |-> port_read_out[$past(ev_pin)] != $past(port_read_out[ev_pin]);
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("pulse without edge");
endmodule
bind priority_port_crossbar priority_port_crossbar_properties chk_i (
   .clk_in, .reset_n_in, .pin_skip_reg_in, .peripheral_route_reg_a_in, .peripheral_route_reg_b_in,
   .port_input_mode_in, .cfg_write_in, .ext_interrupt_config_in, .pad_out, .pad_oe_out,
   .pad_pullup_out, .port_read_out, .event_pulse_out, .pin_routed_out
);

// ==== priority_port_crossbar_tb.sv ====
// self-checking bench for the priority port crossbar
`timescale 1ns/10ps
module priority_port_crossbar_tb;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic cw = 1'b0;
   logic lw = 1'b0;
   logic lr = 1'b0;
   logic [6:0] skip = 7'h00;
   port_crossbar_pkg::route_a_s ra = '0;
   port_crossbar_pkg::route_b_s rb = '0;
   logic [7:0] im = 8'hFF;
   logic [7:0] om = 8'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] xd = 8'h00;
   logic [7:0] xe = 8'h00;
   port_crossbar_pkg::event_cfg_s ev = '0;
   port_crossbar_pkg::periph_out_s pv = '0;
   port_crossbar_pkg::periph_out_s po;
   logic [7:0] pin, pd, oe, pu, rd, rt, c;
   logic sr, ci, evp, td, tc, tmz, tmo, xa;
   int mismatches = 0;
   int n_checks = 0;
   priority_port_crossbar DUT (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .pin_skip_reg_in(skip),
      .peripheral_route_reg_a_in(ra), .peripheral_route_reg_b_in(rb),
      .port_input_mode_in(im), .port_output_mode_in(om), .cfg_write_in(cw),
      .latch_wdata_in(wd), .latch_write_in(lw), .latch_rmw_in(lr),
      .ext_interrupt_config_in(ev), .periph_out_in(po), .pad_in(pin),
      .pad_out(pd), .pad_oe_out(oe), .pad_pullup_out(pu), .port_read_out(rd),
      .serial_receive_out(sr), .twi_data_in_out(td), .twi_clock_in_out(tc),
      .counter_external_input_out(ci), .timer_zero_input_out(tmz), .timer_one_input_out(tmo),
      .event_pulse_out(evp), .pin_routed_out(rt), .crossbar_active_out(xa)
   );
   periph_model far (
      .clk_in(clk_in), .pad_out_in(pd), .pad_oe_in(oe), .pullup_in(pu),
      .ext_level_in(xd), .ext_drive_in(xe), .periph_val_in(pv),
      .pad_level_out(pin), .periph_out(po)
   );
   initial begin
      forever #25 clk_in = ~clk_in;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // enable goes in with its settings
   task automatic cfg(input logic [6:0] s, input logic [7:0] a, b, i, o);
      @(posedge clk_in);
      skip <= s;
      ra <= a;
      rb <= b;
      im <= i;
      om <= o;
      cw <= 1'b1;
      @(posedge clk_in);
      cw <= 1'b0;
      wt(3);
   endtask
   task automatic pulses();
      c = 8'h00;
      repeat (8) begin
         wt(1);
         if (evp === 1'b1) c++;
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_order();
      cfg(7'h04, 8'h2C, 8'h47, 8'hFF, 8'h00);
      chk(rt, 8'hFB);
      chk(oe & 8'h0F, 8'h0B);
      chk({6'h00, tmz, tmo}, 8'h03);
      @(posedge clk_in);
      xe <= 8'h20;
      xd <= 8'h20;
      wt(5);
      chk(ci, 8'h01);
      @(posedge clk_in);
      xd <= 8'h00;
      wt(5);
      chk(ci, 8'h00);
      $display("test order done");
   endtask
   task automatic t_cc();
      for (int n = 0; n < 4; n++) begin
         cfg(7'h0F, {n[1:0], 6'h00}, 8'h40, 8'hFF, 8'h00);
         chk(rt, ((8'h01 << n) - 8'h01) << 4);
      end
      $display("test counter array done");
   endtask
   task automatic t_serial();
      @(posedge clk_in);
      pv <= 9'h180;
      xd <= 8'h00;
      cfg(7'h00, 8'h07, 8'h40, 8'hFF, 8'hFF);
      chk(rt, 8'h33);
      chk(oe & 8'h13, 8'h12);
      chk(pd & 8'h10, 8'h10);
      chk(pu & 8'h03, 8'h01);
      chk(sr, 8'h00);
      wt(2);
      chk({6'h00, td, tc}, 8'h02);
      $display("test serial done");
   endtask
   task automatic t_off();
      cfg(7'h00, 8'hFF, 8'h07, 8'hFF, 8'hFF);
      chk(oe, 8'h00);
      chk(rt, 8'h00);
      chk(xa, 8'h00);
      cfg(7'h00, 8'hFF, 8'h47, 8'hFF, 8'hFF);
      chk(rt, 8'hFF);
      chk(xa, 8'h01);
      cfg(7'h00, 8'hFF, 8'hC7, 8'hFF, 8'h00);
      chk(pu, 8'h00);
      $display("test enable done");
   endtask
   task automatic t_analog();
      @(posedge clk_in);
      ev <= {3'h0, port_crossbar_pkg::EDGE_RISE};
      xe <= 8'h03;
      xd <= 8'h00;
      cfg(7'h01, 8'h00, 8'h41, 8'hFE, 8'h00);
      wt(5);
      chk(rd & 8'h01, 8'h00);
      chk(pu & 8'h03, 8'h02);
      @(posedge clk_in);
      xd <= 8'h01;
      pulses();
      chk(c, 8'h00);
      @(posedge clk_in);
      ev <= {3'h1, port_crossbar_pkg::EDGE_RISE};
      xd <= 8'h03;
      pulses();
      chk(c, 8'h01);
      @(posedge clk_in);
      ev <= {3'h1, port_crossbar_pkg::EDGE_FALL};
      xd <= 8'h01;
      pulses();
      chk(c, 8'h01);
      @(posedge clk_in);
      ev <= {3'h1, port_crossbar_pkg::EDGE_BOTH};
      xd <= 8'h03;
      pulses();
      chk(c, 8'h01);
      @(posedge clk_in);
      ev <= '0;
      $display("test event done");
   endtask
   task automatic t_rmw();
      @(posedge clk_in);
      xe <= 8'h0F;
      xd <= 8'h00;
      cfg(7'h7F, 8'h00, 8'h40, 8'hFF, 8'hF0);
      @(posedge clk_in);
      wd <= 8'hFF;
      lw <= 1'b1;
      @(posedge clk_in);
      wd <= 8'h3C;
      lw <= 1'b0;
      lr <= 1'b1;
      @(posedge clk_in);
      lr <= 1'b0;
      wt(5);
      chk(pd, 8'h3C);
      chk(rd, 8'h30);
      $display("test latch done");
   endtask
   initial begin
      repeat (2000) @(posedge clk_in);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      wt(1);
      chk(oe, 8'h00);
      chk(pu, 8'hFF);
      t_order();
      t_cc();
      t_serial();
      t_off();
      t_analog();
      t_rmw();
      test_done();
   end
endmodule
